// ### rtl/pcn_regs.sv
// Behaviour
// - The phase angle is corrected by a cubic in the measured value using four signed coefficient registers.
// - Five event flags sit in bits 4:0 of the flag register and bits 12:8 enable them one for one.
// - Raw rms current and voltage registers present the 32-bit results of the latest line cycle.
// - Raw active, reactive and apparent energy registers present 32-bit per-line-cycle values.
// - Raw amp-hour registers of phase and neutral present 32-bit per-line-cycle values.
// - A read-only 16-bit neutral amp-hour accumulator steps once per unit of the amp-hour setting.
`timescale 1ns/10ps
module pcn_regs (
    input wire logic clk_sys,
    input wire logic rst,
    input wire pcn_pkg::pcn_host_req_s host_req,
    output logic [pcn_pkg::DATA_W-1:0] rdata,
    output logic rvalid,
    input wire logic meas_strobe,
    input wire pcn_pkg::pcn_meas_s meas,
    input wire logic [pcn_pkg::HALF_W-1:0] current_peak,
    input wire logic [pcn_pkg::HALF_W-1:0] voltage_peak,
    input wire logic [pcn_pkg::FLAG_W-1:0] event_set,
    input wire logic [pcn_pkg::OVF_W-1:0] ovf_set,
    input wire logic [pcn_pkg::HALF_W-1:0] amp_hour_unit_setting,
    input wire logic signed [pcn_pkg::HALF_W-1:0] angle_in,
    output logic [pcn_pkg::ANGLE_W-1:0] angle_corrected,
    output logic [pcn_pkg::DATA_W-1:0] neutral_rms_scaled,
    output logic event_request
);
    import pcn_pkg::*;

    pcn_state_s st;
    pcn_state_s nx;
    logic [DATA_W:0] ah_base;
    logic ah_step;
    logic ah_wrap;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] o);
        return a == o;
    endfunction

    function automatic logic [DATA_W-1:0] half(input logic [HALF_W-1:0] v);
        return {16'h0000, v};
    endfunction

    always_comb begin
        nx = st;
        ah_base = '0;
        ah_step = 1'b0;
        ah_wrap = 1'b0;
        nx.rvalid = 1'b0;
        nx.rdata = '0;
        // Writes to read-only or unmapped offsets are dropped
        if (host_req.wr) begin
            if (hit(host_req.addr, OFS_ANGLE_COEF_CONST)) begin
                nx.coef_const = host_req.wdata[HALF_W-1:0];
            end else if (hit(host_req.addr, OFS_ANGLE_COEF_LIN)) begin
                nx.coef_lin = host_req.wdata[HALF_W-1:0];
            end else if (hit(host_req.addr, OFS_ANGLE_COEF_SQ)) begin
                nx.coef_sq = host_req.wdata[HALF_W-1:0];
            end else if (hit(host_req.addr, OFS_ANGLE_COEF_CUBE)) begin
                nx.coef_cube = host_req.wdata[HALF_W-1:0];
            end else if (hit(host_req.addr, OFS_EVENT_FLAGS)) begin
                nx.evt = st.evt & host_req.wdata[FLAG_W-1:0];
                nx.evt_mask = host_req.wdata[MASK_LSB +: FLAG_W];
            end else if (hit(host_req.addr, OFS_ACCUM_OVERFLOW)) begin
                nx.ovf = st.ovf & host_req.wdata[OVF_W-1:0];
            end else if (hit(host_req.addr, OFS_NEUTRAL_CURRENT_GAIN)) begin
                nx.n_gain = host_req.wdata[HALF_W-1:0];
            end else if (hit(host_req.addr, OFS_NEUTRAL_ACCUM_OVERFLOW)) begin
                nx.n_ovf = st.n_ovf & host_req.wdata[NEUTRAL_AMP_HOUR_OVERFLOW_FLAG];
            end
        end
        // Set beats a clear in the same cycle so no event is lost
        nx.evt = nx.evt | event_set;
        nx.ovf = nx.ovf | ovf_set;
        if (meas_strobe) begin
            nx.meas = meas;
            nx.ipk = current_peak;
            nx.vpk = voltage_peak;
        end
        // Residue carries the part of a unit not yet counted
        ah_base = {1'b0, st.n_resid} + (meas_strobe ? {1'b0, meas.n_ih} : 33'h0_0000_0000);
        if (amp_hour_unit_setting != RESET_HALF && ah_base >= {17'h0_0000, amp_hour_unit_setting}) begin
            ah_step = 1'b1;
            ah_base = ah_base - {17'h0_0000, amp_hour_unit_setting};
            nx.n_ah = st.n_ah + ACCUM_STEP;
            ah_wrap = (st.n_ah == ACCUM_MAX);
        end
        // Limitation: one unit per clock; a huge raw value drains over several cycles
        nx.n_resid = ah_base[DATA_W] ? '1 : ah_base[DATA_W-1:0];
        nx.n_ovf = nx.n_ovf | ah_wrap;
        if (host_req.rd) begin
            nx.rvalid = 1'b1;
            if (hit(host_req.addr, OFS_ANGLE_COEF_CONST)) begin
                nx.rdata = half(st.coef_const);
            end else if (hit(host_req.addr, OFS_ANGLE_COEF_LIN)) begin
                nx.rdata = half(st.coef_lin);
            end else if (hit(host_req.addr, OFS_ANGLE_COEF_SQ)) begin
                nx.rdata = half(st.coef_sq);
            end else if (hit(host_req.addr, OFS_ANGLE_COEF_CUBE)) begin
                nx.rdata = half(st.coef_cube);
            end else if (hit(host_req.addr, OFS_EVENT_FLAGS)) begin
                nx.rdata = half({3'b000, st.evt_mask, 3'b000, st.evt});
            end else if (hit(host_req.addr, OFS_ACCUM_OVERFLOW)) begin
                nx.rdata = half({8'h00, st.ovf});
            end else if (hit(host_req.addr, OFS_CURRENT_PEAK)) begin
                nx.rdata = half(st.ipk);
            end else if (hit(host_req.addr, OFS_VOLTAGE_PEAK)) begin
                nx.rdata = half(st.vpk);
            end else if (hit(host_req.addr, OFS_RAW_RMS_CURRENT)) begin
                nx.rdata = st.meas.irms;
            end else if (hit(host_req.addr, OFS_RAW_RMS_VOLTAGE)) begin
                nx.rdata = st.meas.vrms;
            end else if (hit(host_req.addr, OFS_RAW_AMP_HOURS)) begin
                nx.rdata = st.meas.ih;
            end else if (hit(host_req.addr, OFS_RAW_ACTIVE_ENERGY)) begin
                nx.rdata = st.meas.act;
            end else if (hit(host_req.addr, OFS_RAW_REACTIVE_ENERGY)) begin
                nx.rdata = st.meas.rea;
            end else if (hit(host_req.addr, OFS_RAW_APPARENT_ENERGY)) begin
                nx.rdata = st.meas.app;
            end else if (hit(host_req.addr, OFS_NEUTRAL_AMP_HOUR_ACCUM)) begin
                nx.rdata = half(st.n_ah);
            end else if (hit(host_req.addr, OFS_NEUTRAL_CURRENT_GAIN)) begin
                nx.rdata = half(st.n_gain);
            end else if (hit(host_req.addr, OFS_NEUTRAL_ACCUM_OVERFLOW)) begin
                nx.rdata = half({15'h0000, st.n_ovf});
            end else if (hit(host_req.addr, OFS_NEUTRAL_RAW_RMS_CURRENT)) begin
                nx.rdata = st.meas.n_irms;
            end else if (hit(host_req.addr, OFS_NEUTRAL_RAW_AMP_HOURS)) begin
                nx.rdata = st.meas.n_ih;
            end
        end
        nx.evt_req = |(st.evt & st.evt_mask);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    pcn_math u_math (
        .clk_sys(clk_sys),
        .rst(rst),
        .angle_in(angle_in),
        .coef_const(st.coef_const),
        .coef_lin(st.coef_lin),
        .coef_sq(st.coef_sq),
        .coef_cube(st.coef_cube),
        .gain(st.n_gain),
        .rms_in(st.meas.n_irms),
        .angle_out(angle_corrected),
        .rms_out(neutral_rms_scaled)
    );

    assign rdata = st.rdata;
    assign rvalid = st.rvalid;
    assign event_request = st.evt_req;

    logic ovf_clear_wr;
    assign ovf_clear_wr = host_req.wr && hit(host_req.addr, OFS_ACCUM_OVERFLOW);

    sequence s_read_irms;
        host_req.rd && hit(host_req.addr, OFS_RAW_RMS_CURRENT);
    endsequence

    sequence s_answer_irms;
        rvalid && rdata == $past(st.meas.irms);
    endsequence

    a_evt_set_wins: assert property (@(posedge clk_sys) disable iff (rst)
        (|event_set) |=> ((st.evt & $past(event_set)) == $past(event_set)))
        else $error("event flag lost");

    a_evt_mask_gate: assert property (@(posedge clk_sys) disable iff (rst)
        (st.evt_mask == '0) [*2] |=> !event_request)
        else $error("masked flag raised event request");

    a_ovf_sticky: assert property (@(posedge clk_sys) disable iff (rst)
        (st.ovf[AMP_HOUR_OVERFLOW_FLAG] && !ovf_clear_wr) |=> st.ovf[AMP_HOUR_OVERFLOW_FLAG])
        else $error("overflow flag dropped without write");

    a_ovf_set: assert property (@(posedge clk_sys) disable iff (rst)
        (|ovf_set) |=> ((st.ovf & $past(ovf_set)) == $past(ovf_set)))
        else $error("overflow event lost");

    a_ah_wrap_flag: assert property (@(posedge clk_sys) disable iff (rst)
        (ah_step && st.n_ah == ACCUM_MAX) |=> (st.n_ah == RESET_HALF && st.n_ovf))
        else $error("amp-hour wrap not flagged");

    a_ah_hold: assert property (@(posedge clk_sys) disable iff (rst)
        (amp_hour_unit_setting == RESET_HALF) |=> $stable(st.n_ah))
        else $error("accumulator moved with zero unit");

    a_rms_latch: assert property (@(posedge clk_sys) disable iff (rst)
        meas_strobe |=> (st.meas.irms == $past(meas.irms) && st.meas.vrms == $past(meas.vrms)))
        else $error("rms result not latched");

    a_energy_latch: assert property (@(posedge clk_sys) disable iff (rst)
        meas_strobe |=> (st.meas.act == $past(meas.act) && st.meas.app == $past(meas.app)))
        else $error("energy result not latched");

    a_amp_hour_latch: assert property (@(posedge clk_sys) disable iff (rst)
        meas_strobe |=> (st.meas.ih == $past(meas.ih) && st.meas.n_ih == $past(meas.n_ih)))
        else $error("amp-hour result not latched");

    a_read_irms: assert property (@(posedge clk_sys) disable iff (rst)
        s_read_irms |=> s_answer_irms)
        else $error("rms read returned wrong data");

endmodule

// ### shared/pcn_pkg.sv
package pcn_pkg;

    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int HALF_W = 16;
    localparam int ANGLE_W = 18;

    // Byte offsets of the register bank
    localparam logic [ADDR_W-1:0] OFS_ANGLE_COEF_CONST = 10'h2dc;
    localparam logic [ADDR_W-1:0] OFS_ANGLE_COEF_LIN = 10'h2de;
    localparam logic [ADDR_W-1:0] OFS_ANGLE_COEF_SQ = 10'h2e0;
    localparam logic [ADDR_W-1:0] OFS_ANGLE_COEF_CUBE = 10'h2e2;
    localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS = 10'h2e4;
    localparam logic [ADDR_W-1:0] OFS_ACCUM_OVERFLOW = 10'h2e6;
    localparam logic [ADDR_W-1:0] OFS_CURRENT_PEAK = 10'h2e8;
    localparam logic [ADDR_W-1:0] OFS_VOLTAGE_PEAK = 10'h2ea;
    localparam logic [ADDR_W-1:0] OFS_RAW_RMS_CURRENT = 10'h372;
    localparam logic [ADDR_W-1:0] OFS_RAW_RMS_VOLTAGE = 10'h376;
    localparam logic [ADDR_W-1:0] OFS_RAW_AMP_HOURS = 10'h37a;
    localparam logic [ADDR_W-1:0] OFS_RAW_ACTIVE_ENERGY = 10'h37e;
    localparam logic [ADDR_W-1:0] OFS_RAW_REACTIVE_ENERGY = 10'h382;
    localparam logic [ADDR_W-1:0] OFS_RAW_APPARENT_ENERGY = 10'h386;
    localparam logic [ADDR_W-1:0] OFS_NEUTRAL_AMP_HOUR_ACCUM = 10'h3b0;
    localparam logic [ADDR_W-1:0] OFS_NEUTRAL_CURRENT_GAIN = 10'h3b2;
    localparam logic [ADDR_W-1:0] OFS_NEUTRAL_ACCUM_OVERFLOW = 10'h3b4;
    localparam logic [ADDR_W-1:0] OFS_NEUTRAL_RAW_RMS_CURRENT = 10'h3e4;
    localparam logic [ADDR_W-1:0] OFS_NEUTRAL_RAW_AMP_HOURS = 10'h3e8;

    // Event flag register layout
    localparam int FLAG_W = 5;
    localparam int MASK_LSB = 8;
    localparam int OVERCURRENT_FLAG = 0;
    localparam int OVERVOLTAGE_FLAG = 1;
    localparam int SAG_FLAG = 2;
    localparam int NO_ZERO_CROSS_FLAG = 3;
    localparam int MISSING_VOLTAGE_FLAG = 4;

    // Overflow register layout
    localparam int OVF_W = 8;
    localparam int APPARENT_OVERFLOW_LO_FLAG = 0;
    localparam int ACTIVE_NEGATIVE_OVERFLOW_FLAG = 1;
    localparam int QUAD1_OVERFLOW_FLAG = 2;
    localparam int QUAD2_OVERFLOW_FLAG = 3;
    localparam int QUAD3_OVERFLOW_FLAG = 4;
    localparam int QUAD4_OVERFLOW_FLAG = 5;
    localparam int APPARENT_OVERFLOW_FLAG = 6;
    localparam int AMP_HOUR_OVERFLOW_FLAG = 7;
    localparam int NEUTRAL_AMP_HOUR_OVERFLOW_FLAG = 0;

    localparam logic [HALF_W-1:0] RESET_HALF = 16'h0000;
    localparam logic [HALF_W-1:0] ACCUM_MAX = 16'hffff;
    localparam logic [HALF_W-1:0] ACCUM_STEP = 16'h0001;

    // Fixed-point scaling
    localparam int FRAC_BITS = 15;
    localparam int GAIN_SHIFT = 16;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } pcn_host_req_s;

    typedef struct packed {
        logic [DATA_W-1:0] irms;
        logic [DATA_W-1:0] vrms;
        logic [DATA_W-1:0] ih;
        logic [DATA_W-1:0] act;
        logic [DATA_W-1:0] rea;
        logic [DATA_W-1:0] app;
        logic [DATA_W-1:0] n_irms;
        logic [DATA_W-1:0] n_ih;
    } pcn_meas_s;

    typedef struct packed {
        logic [HALF_W-1:0] coef_const;
        logic [HALF_W-1:0] coef_lin;
        logic [HALF_W-1:0] coef_sq;
        logic [HALF_W-1:0] coef_cube;
        logic [FLAG_W-1:0] evt;
        logic [FLAG_W-1:0] evt_mask;
        logic [OVF_W-1:0] ovf;
        logic [HALF_W-1:0] ipk;
        logic [HALF_W-1:0] vpk;
        pcn_meas_s meas;
        logic [HALF_W-1:0] n_ah;
        logic [HALF_W-1:0] n_gain;
        logic n_ovf;
        logic [DATA_W-1:0] n_resid;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
        logic evt_req;
    } pcn_state_s;

    typedef struct packed {
        logic [ANGLE_W-1:0] angle;
        logic [DATA_W-1:0] rms;
    } pcn_math_s;

endpackage

// ### rtl/pcn_math.sv
`timescale 1ns/10ps
module pcn_math (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic signed [pcn_pkg::HALF_W-1:0] angle_in,
    input wire logic [pcn_pkg::HALF_W-1:0] coef_const,
    input wire logic [pcn_pkg::HALF_W-1:0] coef_lin,
    input wire logic [pcn_pkg::HALF_W-1:0] coef_sq,
    input wire logic [pcn_pkg::HALF_W-1:0] coef_cube,
    input wire logic [pcn_pkg::HALF_W-1:0] gain,
    input wire logic [pcn_pkg::DATA_W-1:0] rms_in,
    output logic [pcn_pkg::ANGLE_W-1:0] angle_out,
    output logic [pcn_pkg::DATA_W-1:0] rms_out
);
    import pcn_pkg::*;

    pcn_math_s st;
    pcn_math_s nx;
    logic signed [31:0] sq_full;
    logic signed [32:0] cube_full;
    logic signed [16:0] x2;
    logic signed [16:0] x3;
    logic signed [32:0] t1;
    logic signed [32:0] t2;
    logic signed [32:0] t3;
    logic signed [33:0] poly;
    logic signed [48:0] gprod;
    logic signed [33:0] gtot;

    always_comb begin
        nx = st;
        // Q15 powers of the measured value
        sq_full = angle_in * angle_in;
        x2 = 17'(sq_full >>> FRAC_BITS);
        cube_full = x2 * angle_in;
        x3 = 17'(cube_full >>> FRAC_BITS);
        t1 = $signed(coef_lin) * angle_in;
        t2 = $signed(coef_sq) * x2;
        t3 = $signed(coef_cube) * x3;
        poly = 34'($signed(coef_const)) + 34'(t1 >>> FRAC_BITS) + 34'(t2 >>> FRAC_BITS)
            + 34'(t3 >>> FRAC_BITS);
        // Two guard bits cover the worst-case sum of the four terms
        nx.angle = poly[ANGLE_W-1:0];
        gprod = $signed({1'b0, rms_in}) * $signed(gain);
        gtot = $signed({2'b00, rms_in}) + 34'(gprod >>> GAIN_SHIFT);
        // Saturate rather than wrap so a large gain cannot fold a reading to zero
        if (gtot < 0) begin
            nx.rms = '0;
        end else if (gtot[33:32] != 2'b00) begin
            nx.rms = '1;
        end else begin
            nx.rms = gtot[DATA_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

    assign angle_out = st.angle;
    assign rms_out = st.rms;

    logic [ANGLE_W-1:0] c0_ext;
    assign c0_ext = {{2{coef_const[HALF_W-1]}}, coef_const};

    a_poly_const_only: assert property (@(posedge clk_sys) disable iff (rst)
        (coef_lin == RESET_HALF && coef_sq == RESET_HALF && coef_cube == RESET_HALF)
        |=> angle_out == $past(c0_ext))
        else $error("angle output differs from constant term");

    a_gain_unity: assert property (@(posedge clk_sys) disable iff (rst)
        (gain == RESET_HALF) |=> rms_out == $past(rms_in))
        else $error("zero gain altered rms value");

endmodule

// ### dv/pcn_host_model.sv
`timescale 1ns/10ps
module pcn_host_model (
    input wire logic clk_sys,
    output pcn_pkg::pcn_host_req_s host_req,
    input wire logic [pcn_pkg::DATA_W-1:0] rdata,
    input wire logic rvalid
);
    import pcn_pkg::*;

    initial host_req = '0;

    // Released lines are scrambled so a stale address never looks valid
    task automatic release_bus();
        host_req.wr = 1'b0;
        host_req.rd = 1'b0;
        host_req.addr = ~host_req.addr;
        host_req.wdata = ~host_req.wdata;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge clk_sys);
        host_req.wr = 1'b1;
        host_req.addr = a;
        host_req.wdata = d;
        @(negedge clk_sys);
        release_bus();
    endtask

    // Answer is registered on the taking edge and stands one cycle
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                      output logic v);
        @(negedge clk_sys);
        host_req.rd = 1'b1;
        host_req.addr = a;
        @(negedge clk_sys);
        // Answer stands only until the next rising edge, so take it here
        d = rdata;
        v = rvalid;
        release_bus();
    endtask
endmodule

// ### dv/pcn_regs_tb.sv
`timescale 1ns/10ps
module pcn_regs_tb;
    import pcn_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    pcn_host_req_s host_req;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic meas_strobe = 1'b0;
    pcn_meas_s meas = '0;
    logic [HALF_W-1:0] current_peak = '0;
    logic [HALF_W-1:0] voltage_peak = '0;
    logic [FLAG_W-1:0] event_set = '0;
    logic [OVF_W-1:0] ovf_set = '0;
    logic [HALF_W-1:0] amp_hour_unit_setting = '0;
    logic signed [HALF_W-1:0] angle_in = '0;
    logic [ANGLE_W-1:0] angle_corrected;
    logic [DATA_W-1:0] neutral_rms_scaled;
    logic event_request;
    int err_total = 0;
    int comparisons = 0;
    logic [DATA_W-1:0] got;
    logic vld;
    localparam logic [ADDR_W-1:0] RW_OFS [8] = '{OFS_ANGLE_COEF_CONST,
        OFS_ANGLE_COEF_LIN, OFS_ANGLE_COEF_SQ, OFS_ANGLE_COEF_CUBE,
        OFS_NEUTRAL_CURRENT_GAIN, OFS_EVENT_FLAGS, OFS_ACCUM_OVERFLOW,
        OFS_NEUTRAL_ACCUM_OVERFLOW};
    localparam logic [ADDR_W-1:0] MS_OFS [7] = '{OFS_RAW_RMS_CURRENT,
        OFS_RAW_RMS_VOLTAGE, OFS_RAW_AMP_HOURS, OFS_RAW_ACTIVE_ENERGY,
        OFS_RAW_REACTIVE_ENERGY, OFS_RAW_APPARENT_ENERGY,
        OFS_NEUTRAL_RAW_RMS_CURRENT};
    localparam logic [HALF_W-1:0] ANG [4] = '{16'h0100, 16'h4000, 16'h4000, 16'h4000};

    always #4 clk_sys = ~clk_sys;

    pcn_host_model host (.clk_sys(clk_sys), .host_req(host_req), .rdata(rdata),
        .rvalid(rvalid));

    pcn_regs dut (.clk_sys(clk_sys), .rst(rst), .host_req(host_req), .rdata(rdata),
        .rvalid(rvalid), .meas_strobe(meas_strobe), .meas(meas),
        .current_peak(current_peak), .voltage_peak(voltage_peak),
        .event_set(event_set), .ovf_set(ovf_set),
        .amp_hour_unit_setting(amp_hour_unit_setting), .angle_in(angle_in),
        .angle_corrected(angle_corrected), .neutral_rms_scaled(neutral_rms_scaled),
        .event_request(event_request));

    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        host.rd(a, got, vld);
        chk({31'h0, vld}, 32'h1);
        chk(got, exp);
        @(negedge clk_sys);
        chk({31'h0, rvalid}, 32'h0);
    endtask

    task automatic pulse(input int b, input logic ovf);
        @(negedge clk_sys);
        if (ovf) begin
            ovf_set[b] = 1'b1;
        end else begin
            event_set[b] = 1'b1;
        end
        @(negedge clk_sys);
        ovf_set = '0;
        event_set = '0;
    endtask

    task automatic strobe();
        @(negedge clk_sys);
        meas_strobe = 1'b1;
        @(negedge clk_sys);
        meas_strobe = 1'b0;
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #800000;
        err_total++;
        give_verdict();
    end

    initial begin
        logic [HALF_W-1:0] v;
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd_chk(RW_OFS[i], 32'h0);
        end
        for (int i = 0; i < 5; i++) begin
            v = 16'h1111 * HALF_W'(i + 1);
            host.wr(RW_OFS[i], {16'hffff, v});
            rd_chk(RW_OFS[i], {16'h0, v});
        end
        host.wr(OFS_RAW_RMS_CURRENT, 32'h5a5a5a5a);
        rd_chk(OFS_RAW_RMS_CURRENT, 32'h0);
        rd_chk(10'h300, 32'h0);
        $display("test access done");
        // Neutral amp-hours left at zero so the residue stays empty
        for (int k = 0; k < 7; k++) begin
            meas[255-32*k -: 32] = 32'h01010101 * DATA_W'(k + 1);
        end
        current_peak = 16'hc001;
        voltage_peak = 16'hc002;
        strobe();
        meas = ~meas;
        current_peak = 16'h0;
        voltage_peak = 16'h0;
        for (int k = 0; k < 7; k++) begin
            rd_chk(MS_OFS[k], 32'h01010101 * DATA_W'(k + 1));
        end
        rd_chk(OFS_CURRENT_PEAK, 32'hc001);
        rd_chk(OFS_VOLTAGE_PEAK, 32'hc002);
        $display("test results done");
        for (int b = 0; b < 5; b++) begin
            pulse(b, 1'b0);
            rd_chk(OFS_EVENT_FLAGS, (32'h1 << (b + 1)) - 1);
        end
        chk({31'h0, event_request}, 32'h0);
        host.wr(OFS_EVENT_FLAGS, 32'h0000841f);
        rd_chk(OFS_EVENT_FLAGS, 32'h0000041f);
        chk({31'h0, event_request}, 32'h1);
        host.wr(OFS_EVENT_FLAGS, 32'h0000041b);
        rd_chk(OFS_EVENT_FLAGS, 32'h0000041b);
        chk({31'h0, event_request}, 32'h0);
        // Clear and set in one cycle: the set must survive
        fork
            host.wr(OFS_EVENT_FLAGS, 32'h0);
            pulse(0, 1'b0);
        join
        rd_chk(OFS_EVENT_FLAGS, 32'h00000001);
        for (int b = 0; b < 8; b++) begin
            pulse(b, 1'b1);
        end
        rd_chk(OFS_ACCUM_OVERFLOW, 32'hff);
        host.wr(OFS_ACCUM_OVERFLOW, 32'h0f);
        repeat (5) @(negedge clk_sys);
        rd_chk(OFS_ACCUM_OVERFLOW, 32'h0f);
        fork
            host.wr(OFS_ACCUM_OVERFLOW, 32'h0);
            pulse(7, 1'b1);
        join
        rd_chk(OFS_ACCUM_OVERFLOW, 32'h80);
        $display("test flags done");
        meas = '0;
        meas.n_ih = 32'h9;
        amp_hour_unit_setting = 16'h4;
        strobe();
        repeat (10) @(negedge clk_sys);
        rd_chk(OFS_NEUTRAL_AMP_HOUR_ACCUM, 32'h2);
        rd_chk(OFS_NEUTRAL_RAW_AMP_HOURS, 32'h9);
        host.wr(OFS_NEUTRAL_AMP_HOUR_ACCUM, 32'h1234);
        rd_chk(OFS_NEUTRAL_AMP_HOUR_ACCUM, 32'h2);
        // Leftover residue of one takes the count to three first
        amp_hour_unit_setting = 16'h1;
        repeat (5) @(negedge clk_sys);
        meas.n_ih = 32'hfffd;
        meas.n_irms = 32'h00010000;
        strobe();
        repeat (16'hfffd + 20) @(negedge clk_sys);
        rd_chk(OFS_NEUTRAL_AMP_HOUR_ACCUM, 32'h0);
        rd_chk(OFS_NEUTRAL_ACCUM_OVERFLOW, 32'h1);
        host.wr(OFS_NEUTRAL_ACCUM_OVERFLOW, 32'h0);
        rd_chk(OFS_NEUTRAL_ACCUM_OVERFLOW, 32'h0);
        $display("test accumulator done");
        host.wr(OFS_NEUTRAL_CURRENT_GAIN, 32'h4000);
        repeat (4) @(negedge clk_sys);
        chk(neutral_rms_scaled, 32'h00014000);
        host.wr(OFS_NEUTRAL_CURRENT_GAIN, 32'h8000);
        repeat (4) @(negedge clk_sys);
        chk(neutral_rms_scaled, 32'h00008000);
        // No raw amp-hours here, or the accumulator would drain for another 64k cycles
        meas.n_ih = '0;
        meas.n_irms = 32'hffff0000;
        strobe();
        repeat (4) @(negedge clk_sys);
        chk(neutral_rms_scaled, 32'h7fff8000);
        host.wr(OFS_NEUTRAL_CURRENT_GAIN, 32'h4000);
        repeat (4) @(negedge clk_sys);
        chk(neutral_rms_scaled, 32'hffffffff);
        for (int i = 0; i < 4; i++) begin
            host.wr(RW_OFS[i], {16'h0, ANG[i]});
        end
        angle_in = 16'sh2000;
        repeat (4) @(negedge clk_sys);
        chk({14'h0, angle_corrected}, 32'h1600);
        angle_in = 16'she000;
        repeat (4) @(negedge clk_sys);
        chk({14'h0, angle_corrected}, 32'h3f400);
        $display("test math done");
        rst = 1'b1;
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        rd_chk(OFS_ANGLE_COEF_CONST, 32'h0);
        rd_chk(OFS_ACCUM_OVERFLOW, 32'h0);
        chk({14'h0, angle_corrected}, 32'h0);
        $display("test reset done");
        give_verdict();
    end
endmodule
